// ---- common/adc_ctrl_pkg.sv ----
`default_nettype none

package adc_ctrl_pkg;

    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 8;
    localparam int unsigned RES_W  = 10;
    localparam int unsigned CH_W   = 3;
    localparam int unsigned NUM_CH = 7;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CTRL     = 8'h34;
    localparam logic [7:0] IDX_HIGH     = 8'h35;
    localparam logic [7:0] IDX_LOW      = 8'h36;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h37;
    localparam logic [7:0] IDX_IRQ_CLR  = 8'h38;
    localparam logic [7:0] IDX_IRQ_EN   = 8'h39;

    localparam int unsigned CTRL_DONE_BIT = 7;
    localparam int unsigned CTRL_RATE_BIT = 6;
    localparam int unsigned CTRL_PWR_BIT  = 5;
    localparam int unsigned LOW_CAL_BIT   = 4;
    localparam int unsigned LOW_SLOW_BIT  = 3;
    localparam int unsigned LOW_AMP_BIT   = 2;
    localparam int unsigned IRQ_DONE_BIT  = 0;

    localparam logic            FIELD_RESET = 1'b0;
    localparam logic [CH_W-1:0] CH_RESET    = 3'h0;
    localparam logic [RES_W-1:0] RES_RESET  = 10'h000;
    localparam logic [RES_W-1:0] RES_MSB    = 10'h200;

    localparam logic [2:0] SAMPLE_TICKS = 3'h4;

    typedef enum logic [1:0] {
        RATE_DIV2 = 2'h0,
        RATE_DIV1 = 2'h1,
        RATE_DIV4 = 2'h2
    } rate_e;

    typedef enum logic [1:0] {
        SAR_OFF     = 2'h0,
        SAR_SAMPLE  = 2'h1,
        SAR_CONVERT = 2'h3
    } sar_state_e;

    localparam logic [1:0] DIV_LIMIT1 = 2'h0;
    localparam logic [1:0] DIV_LIMIT2 = 2'h1;
    localparam logic [1:0] DIV_LIMIT4 = 2'h3;

    function automatic logic [ADDR_W-1:0] addr_of(input logic [7:0] idx);
        addr_of = {idx, 2'b00};
    endfunction : addr_of

    function automatic rate_e rate_of(input logic slow, input logic speed);
        if (slow)
            rate_of = RATE_DIV4;
        else if (speed)
            rate_of = RATE_DIV1;
        else
            rate_of = RATE_DIV2;
    endfunction : rate_of

    function automatic logic [1:0] div_limit(input rate_e mode);
        case (mode)
            RATE_DIV1: div_limit = DIV_LIMIT1;
            RATE_DIV4: div_limit = DIV_LIMIT4;
            default:   div_limit = DIV_LIMIT2;
        endcase
    endfunction : div_limit

    function automatic logic [NUM_CH-1:0] chan_onehot(input logic [CH_W-1:0] ch);
        chan_onehot = '0;
        for (int i = 0; i < NUM_CH; i++)
            chan_onehot[i] = (ch == CH_W'(i));
    endfunction : chan_onehot

endpackage : adc_ctrl_pkg

`default_nettype wire

// ---- rtl/adc_clock_divider.sv ----
`timescale 1ns/1ps
`default_nettype none

module adc_clock_divider
    import adc_ctrl_pkg::*;
(
    input  wire logic  pclk,
    input  wire logic  presetn,
    input  wire logic  run,
    input  wire rate_e mode,
    output logic       tick_q
);

    logic [1:0] cnt_q;

    // One tick per converter clock period, counted in CPU clocks.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q  <= DIV_LIMIT1;
            tick_q <= FIELD_RESET;
        end
        else if (!run || cnt_q >= div_limit(mode))
        begin
            cnt_q  <= DIV_LIMIT1;
            tick_q <= run;
        end
        else
        begin
            cnt_q  <= cnt_q + 2'h1;
            tick_q <= FIELD_RESET;
        end
    end

    a_div1_ticks: assert property (@(posedge pclk) disable iff (!presetn)
        (run && mode == RATE_DIV1) [*2] |-> tick_q)
        else $error("full-rate converter clock missed a tick");

    a_div4_gap: assert property (@(posedge pclk) disable iff (!presetn)
        (tick_q && run && mode == RATE_DIV4) ##1 (run && mode == RATE_DIV4) [*3]
        |-> !$past(tick_q) && !$past(tick_q, 2))
        else $error("quarter-rate converter clock ticked too often");

endmodule : adc_clock_divider

`default_nettype wire

// ---- rtl/adc_sar_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none

module adc_sar_sequencer
    import adc_ctrl_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             tick,
    input  wire logic             power_on,
    input  wire logic             cmp_high,
    output logic                  sample_q,
    output logic [RES_W-1:0]      trial_q,
    output logic [RES_W-1:0]      result_q,
    output logic                  done_q
);

    sar_state_e       state_q;
    logic [2:0]       cnt_q;
    logic [RES_W-1:0] bit_q;
    logic [RES_W-1:0] kept;

    // The comparator reports the input at or above the trial level.
    assign kept = cmp_high ? trial_q : (trial_q & ~bit_q);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q  <= SAR_OFF;
            cnt_q    <= SAMPLE_TICKS;
            bit_q    <= RES_MSB;
            trial_q  <= RES_RESET;
            result_q <= RES_RESET;
            sample_q <= FIELD_RESET;
            done_q   <= FIELD_RESET;
        end
        else
        begin
            done_q <= FIELD_RESET;
            if (!power_on)
            begin
                state_q  <= SAR_OFF;
                sample_q <= FIELD_RESET;
            end
            else
            begin
                case (state_q)
                    SAR_OFF:
                    begin
                        state_q  <= SAR_SAMPLE;
                        cnt_q    <= '0;
                        sample_q <= 1'b1;
                    end
                    SAR_SAMPLE:
                    begin
                        if (tick)
                        begin
                            cnt_q <= cnt_q + 3'h1;
                            if (cnt_q == SAMPLE_TICKS - 3'h1)
                            begin
                                state_q  <= SAR_CONVERT;
                                sample_q <= FIELD_RESET;
                                bit_q    <= RES_MSB;
                                trial_q  <= RES_MSB;
                            end
                        end
                    end
                    SAR_CONVERT:
                    begin
                        if (tick)
                        begin
                            if (bit_q[0])
                            begin
                                result_q <= kept;
                                done_q   <= 1'b1;
                                state_q  <= SAR_SAMPLE;
                                cnt_q    <= '0;
                                sample_q <= 1'b1;
                            end
                            else
                            begin
                                trial_q <= kept | (bit_q >> 1);
                                bit_q   <= bit_q >> 1;
                            end
                        end
                    end
                    default:
                        state_q <= SAR_OFF;
                endcase
            end
        end
    end

    a_power_off: assert property (@(posedge pclk) disable iff (!presetn)
        !power_on |=> state_q == SAR_OFF && !sample_q && !done_q)
        else $error("converter kept running with power off");

    a_conv_start: assert property (@(posedge pclk) disable iff (!presetn)
        power_on && state_q == SAR_OFF |=> state_q == SAR_SAMPLE && sample_q)
        else $error("converter did not start after power on");

    a_result_load: assert property (@(posedge pclk) disable iff (!presetn)
        done_q |-> $past(state_q) == SAR_CONVERT && $past(bit_q[0]) && sample_q)
        else $error("result loaded outside the last conversion step");

endmodule : adc_sar_sequencer

`default_nettype wire

// ---- rtl/adc_control_result_regs.sv ----
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module adc_control_result_regs
    import adc_ctrl_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [DATA_W-1:0]   pwdata,
    input  wire logic [DATA_W/8-1:0] pstrb,
    output logic      [DATA_W-1:0]   prdata,
    output logic                     pready,
    output logic                     pslverr,
    output logic                     irq,
    input  wire logic                cmp_high,
    output logic                     converter_power_on,
    output logic      [NUM_CH-1:0]   input_channel_sel,
    output logic                     amp_select,
    output logic                     amp_zero_calibrate,
    output logic                     sample_hold,
    output logic      [RES_W-1:0]    trial_code
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------

    logic              done_q;
    logic              rate_q;
    logic              power_q;
    logic [CH_W-1:0]   ch_q;
    logic              cal_q;
    logic              slow_q;
    logic              amp_q;
    logic              irq_stat_q;
    logic              irq_en_q;
    logic              irq_q;
    logic [NUM_CH-1:0] chan_sel_q;
    logic [DATA_W-1:0] prdata_q;
    logic              pready_q;
    logic              pslverr_q;

    logic              setup;
    logic              access;
    logic              wr_en;
    logic              rd_en;
    logic              wr_low_byte;
    logic              high_read;
    logic              done_d;
    logic              irq_stat_d;

    logic              tick;
    logic              sar_done;
    logic              sar_sample;
    logic [RES_W-1:0]  sar_trial;
    logic [RES_W-1:0]  sar_result;

    // ------------------------------------------------------------
    // Address decoding and read data
    // ------------------------------------------------------------

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        if (a == addr_of(IDX_CTRL))
            reg_hit = 1'b1;
        else if (a == addr_of(IDX_HIGH))
            reg_hit = 1'b1;
        else if (a == addr_of(IDX_LOW))
            reg_hit = 1'b1;
        else if (a == addr_of(IDX_IRQ_STAT))
            reg_hit = 1'b1;
        else if (a == addr_of(IDX_IRQ_CLR))
            reg_hit = 1'b1;
        else if (a == addr_of(IDX_IRQ_EN))
            reg_hit = 1'b1;
        else
            reg_hit = 1'b0;
    endfunction : reg_hit

    function automatic logic [REG_W-1:0] rd_byte(input logic [ADDR_W-1:0] a);
        rd_byte = '0;
        if (a == addr_of(IDX_CTRL))
        begin
            rd_byte[CTRL_DONE_BIT] = done_q;
            rd_byte[CTRL_RATE_BIT] = rate_q;
            rd_byte[CTRL_PWR_BIT]  = power_q;
            rd_byte[CH_W-1:0]      = ch_q;
        end
        else if (a == addr_of(IDX_HIGH))
            rd_byte = sar_result[RES_W-1:2];
        else if (a == addr_of(IDX_LOW))
        begin
            rd_byte[LOW_CAL_BIT]  = cal_q;
            rd_byte[LOW_SLOW_BIT] = slow_q;
            rd_byte[LOW_AMP_BIT]  = amp_q;
            rd_byte[1:0]          = sar_result[1:0];
        end
        else if (a == addr_of(IDX_IRQ_STAT))
            rd_byte[IRQ_DONE_BIT] = irq_stat_q;
        else if (a == addr_of(IDX_IRQ_EN))
            rd_byte[IRQ_DONE_BIT] = irq_en_q;
    endfunction : rd_byte

    assign setup       = psel && !penable;
    assign access      = psel && penable && pready_q && !pslverr_q;
    assign wr_en       = access && pwrite;
    assign rd_en       = access && !pwrite;
    assign wr_low_byte = wr_en && pstrb[0];
    assign high_read   = rd_en && paddr == addr_of(IDX_HIGH);

    // ------------------------------------------------------------
    // APB slave: one wait-free access phase per transfer
    // ------------------------------------------------------------

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= FIELD_RESET;
            pslverr_q <= FIELD_RESET;
            prdata_q  <= '0;
        end
        else
        begin
            pready_q  <= setup;
            pslverr_q <= setup && !reg_hit(paddr);
            if (setup && !pwrite)
                prdata_q <= {{(DATA_W-REG_W){1'b0}}, rd_byte(paddr)};
            else
                prdata_q <= '0;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------

    // Reserved control bits and the done flag are not stored on write.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rate_q  <= FIELD_RESET;
            power_q <= FIELD_RESET;
            ch_q    <= CH_RESET;
        end
        else if (wr_low_byte && paddr == addr_of(IDX_CTRL))
        begin
            rate_q  <= pwdata[CTRL_RATE_BIT];
            power_q <= pwdata[CTRL_PWR_BIT];
            ch_q    <= pwdata[CH_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cal_q  <= FIELD_RESET;
            slow_q <= FIELD_RESET;
            amp_q  <= FIELD_RESET;
        end
        else if (wr_low_byte && paddr == addr_of(IDX_LOW))
        begin
            cal_q  <= pwdata[LOW_CAL_BIT];
            slow_q <= pwdata[LOW_SLOW_BIT];
            amp_q  <= pwdata[LOW_AMP_BIT];
        end
    end

    // ------------------------------------------------------------
    // Done flag: a finishing conversion wins over a clearing read
    // ------------------------------------------------------------

    assign done_d = sar_done || (done_q && !high_read);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            done_q <= FIELD_RESET;
        else
            done_q <= done_d;
    end

    // ------------------------------------------------------------
    // Interrupt status, clear and enable
    // ------------------------------------------------------------

    assign irq_stat_d = sar_done || (irq_stat_q && !(wr_low_byte
                        && paddr == addr_of(IDX_IRQ_CLR) && pwdata[IRQ_DONE_BIT]));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat_q <= FIELD_RESET;
            irq_en_q   <= FIELD_RESET;
            irq_q      <= FIELD_RESET;
        end
        else
        begin
            irq_stat_q <= irq_stat_d;
            if (wr_low_byte && paddr == addr_of(IDX_IRQ_EN))
                irq_en_q <= pwdata[IRQ_DONE_BIT];
            irq_q <= irq_stat_q && irq_en_q;
        end
    end

    assign irq = irq_q;

    // ------------------------------------------------------------
    // Analog side controls
    // ------------------------------------------------------------

    // Code seven selects no input at all.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            chan_sel_q <= '0;
        else
            chan_sel_q <= chan_onehot(ch_q);
    end

    assign input_channel_sel  = chan_sel_q;
    assign converter_power_on = power_q;
    assign amp_select         = amp_q;
    assign amp_zero_calibrate = cal_q;
    assign sample_hold        = sar_sample;
    assign trial_code         = sar_trial;

    // ------------------------------------------------------------
    // Converter clock and conversion sequencer
    // ------------------------------------------------------------

    adc_clock_divider u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (power_q),
        .mode    (rate_of(slow_q, rate_q)),
        .tick_q  (tick)
    );

    adc_sar_sequencer u_sar (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick     (tick),
        .power_on (power_q),
        .cmp_high (cmp_high),
        .sample_q (sar_sample),
        .trial_q  (sar_trial),
        .result_q (sar_result),
        .done_q   (sar_done)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    a_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
        sar_done |=> done_q)
        else $error("done flag not set after conversion");

    a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
        high_read && !sar_done |=> !done_q)
        else $error("high byte read did not clear done flag");

    a_ctrl_ro: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == addr_of(IDX_CTRL) && !sar_done && !high_read
        |=> done_q == $past(done_q))
        else $error("software write changed the done flag");

    a_chan_none: assert property (@(posedge pclk) disable iff (!presetn)
        ch_q == CH_W'(NUM_CH) ##1 ch_q == CH_W'(NUM_CH) |-> chan_sel_q == '0)
        else $error("unused channel code routed an input");

    a_high_read: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == addr_of(IDX_HIGH)
        |=> prdata_q[REG_W-1:0] == $past(sar_result[RES_W-1:2]))
        else $error("high byte does not show result bits 9 to 2");

    a_low_zero: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == addr_of(IDX_LOW)
        |=> prdata_q[DATA_W-1:5] == '0
            && prdata_q[1:0] == $past(sar_result[1:0]))
        else $error("low register upper bits or result bits wrong");

    a_cal_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_low_byte && paddr == addr_of(IDX_LOW)
        |=> amp_zero_calibrate == $past(pwdata[LOW_CAL_BIT])
            && amp_select == $past(pwdata[LOW_AMP_BIT]))
        else $error("amplifier controls did not follow a write");

    a_done_irq: assert property (@(posedge pclk) disable iff (!presetn)
        sar_done && irq_en_q ##1 irq_en_q |=> irq)
        else $error("enabled conversion event raised no interrupt");

endmodule : adc_control_result_regs

`default_nettype wire

// ---- verif/adc_analog_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module adc_analog_model
    import adc_ctrl_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              power_on,
    input  wire logic [NUM_CH-1:0] chan_sel,
    input  wire logic              amp_on,
    input  wire logic              amp_cal,
    input  wire logic [RES_W-1:0]  trial,
    input  wire logic [10:0]       lvl [NUM_CH],
    output logic                   cmp_high
);
    // ----------------------------------------------------------------
    // Comparator against the trial word
    // ----------------------------------------------------------------
    logic [13:0] vin;
    logic        hit;
    logic        tog_q = 1'b0;

    // While unpowered the comparator output wanders, so stale values never pass.
    always_ff @(posedge pclk)
        tog_q <= ~tog_q;

    always_comb
    begin
        vin = '0;
        hit = 1'b0;
        for (int i = 0; i < NUM_CH; i++)
            if (chan_sel[i])
            begin
                vin = {3'h0, lvl[i]};
                hit = 1'b1;
            end
        if (amp_on)
            vin = amp_cal ? 14'h0000 : {vin[10:0], 3'h0};
        cmp_high = (power_on && hit) ? (vin >= {4'h0, trial}) : tog_q;
    end
endmodule : adc_analog_model

`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import adc_ctrl_pkg::*;
    logic              pclk    = 1'b0;
    logic              presetn = 1'b0;
    logic [ADDR_W-1:0] paddr   = '0;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [31:0]       pwdata  = '0;
    logic [3:0]        pstrb   = '0;
    logic [31:0]       prdata;
    logic              pready, pslverr, irq, cmp_high, pwr, amp, cal, shold;
    logic [NUM_CH-1:0] chsel;
    logic [RES_W-1:0]  trial;
    logic [10:0]       lvl [NUM_CH];
    logic [31:0]       rd;
    logic              re;
    logic [9:0]        e;
    logic [1:0]        m;
    logic [2:0]        c;
    int                err_total   = 0;
    int                check_count = 0;

    initial forever #12.5 pclk = ~pclk;

    adc_control_result_regs i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .cmp_high(cmp_high), .converter_power_on(pwr), .input_channel_sel(chsel),
        .amp_select(amp), .amp_zero_calibrate(cal), .sample_hold(shold),
        .trial_code(trial));

    adc_analog_model i_ana (.pclk(pclk), .power_on(pwr), .chan_sel(chsel), .amp_on(amp),
        .amp_cal(cal), .trial(trial), .lvl(lvl), .cmp_high(cmp_high));

    // ----------------------------------------------------------------
    // Bus, compare and closing tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    task automatic chk_word(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk_word

    task automatic chk_flag(input logic g, input logic x);
        check_count++;
        if (g !== x)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk_flag

    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                       input logic [3:0] s = 4'hf);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the edge at which pready is sampled high; only the watchdog ends a hang.
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_done();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, IDX_CTRL, 32'h0);
            n++;
        end
        while (rd[7] !== 1'b1 && n < 300);
        chk_flag(rd[7], 1'b1);
    endtask : wait_done

    function automatic logic [9:0] exp_res(input logic [10:0] l, input logic a,
                                           input logic z);
        logic [13:0] v;
        v = a ? (z ? 14'h0 : {l, 3'h0}) : {3'h0, l};
        return (v > 14'h3ff) ? 10'h3ff : v[9:0];
    endfunction : exp_res

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial
    begin
        #(25 * 40000);
        err_total++;
        complete_run();
    end

    initial
    begin
        void'($urandom(32'hdd698627));
        for (int i = 0; i < NUM_CH; i++)
            lvl[i] = 11'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, IDX_CTRL, 32'h0);
        chk_word(rd, 32'h0);
        apb(1'b0, IDX_LOW, 32'h0);
        chk_word(rd & 32'hfc, 32'h0);
        apb(1'b0, 8'hff, 32'h0);
        chk_flag(re, 1'b1);
        apb(1'b1, IDX_CTRL, 32'hc7, 4'he);
        apb(1'b0, IDX_CTRL, 32'h0);
        chk_word(rd, 32'h0);
        apb(1'b1, IDX_CTRL, 32'hc7);
        apb(1'b0, IDX_CTRL, 32'h0);
        chk_word(rd, 32'h47);
        chk_word({25'h0, chsel}, 32'h0);
        apb(1'b1, IDX_LOW, 32'hff);
        apb(1'b0, IDX_LOW, 32'h0);
        chk_word(rd, 32'h1c);
        chk_flag(amp, 1'b1);
        chk_flag(cal, 1'b1);
        apb(1'b1, IDX_HIGH, 32'hff);
        apb(1'b0, IDX_HIGH, 32'h0);
        chk_word(rd, 32'h0);
        for (int k = 0; k < 8; k++)
        begin
            c = 3'($urandom_range(0, 6));
            m = 2'($urandom_range(0, 3));
            if (k[0])
                m[1] = 1'b1;
            else
                m = 2'(k >> 1);
            for (int i = 0; i < NUM_CH; i++)
                lvl[i] = 11'($urandom_range(0, 1100));
            if (k == 0)
                lvl[c] = 11'h7ff;
            if (k == 2)
                lvl[c] = 11'h0;
            e = exp_res(lvl[c], k[0], k == 5);
            apb(1'b1, IDX_LOW, {27'h0, k == 5, m[1], k[0], 2'h0});
            apb(1'b1, IDX_IRQ_EN, {31'h0, k[1]});
            apb(1'b1, IDX_CTRL, {24'h0, 1'b0, m[0], 1'b1, 2'h0, c});
            repeat (2) @(posedge pclk);
            chk_word({25'h0, chsel}, 32'h1 << c);
            chk_flag(pwr, 1'b1);
            chk_flag(amp, k[0]);
            chk_flag(shold, 1'b1);
            wait_done();
            apb(1'b0, IDX_HIGH, 32'h0);
            chk_word(rd, {24'h0, e[9:2]});
            wait_done();
            @(negedge pclk);
            chk_flag(irq, k[1]);
            apb(1'b1, IDX_CTRL, {24'h0, 1'b0, m[0], 1'b0, 2'h0, c});
            repeat (2) @(posedge pclk);
            chk_flag(pwr, 1'b0);
            chk_flag(shold, 1'b0);
            apb(1'b0, IDX_LOW, 32'h0);
            chk_word(rd & 32'h3, {30'h0, e[1:0]});
            chk_word(rd & 32'hfc, {27'h0, k == 5, m[1], k[0], 2'h0});
            apb(1'b0, IDX_HIGH, 32'h0);
            chk_word(rd, {24'h0, e[9:2]});
            apb(1'b0, IDX_CTRL, 32'h0);
            chk_flag(rd[7], 1'b0);
            apb(1'b1, IDX_IRQ_CLR, 32'h1);
            repeat (2) @(negedge pclk);
            chk_flag(irq, 1'b0);
        end
        complete_run();
    end
endmodule : tb_top

`default_nettype wire
